// *** core/dcp_pkg.sv ***
package dcp_pkg;
	// ****************************************************************
	// Geometry
	// ****************************************************************
	localparam int NUM_CH      = 32;
	localparam int NUM_GRP     = 4;
	localparam int GRP_CH      = 8;
	localparam int CH_W        = 5;
	localparam int GRP_W       = 2;
	localparam int PICK_W      = 6;
	localparam int MAX_W       = 16;
	localparam int WIDTH_16    = 16;
	localparam int WIDTH_14    = 14;
	localparam int OFS_W       = 14;
	localparam int OFS_OUT_W   = 16;
	localparam int OFS_SHIFT16 = 2;

	// ****************************************************************
	// Write kinds
	// ****************************************************************
	localparam int              KIND_W     = 4;
	localparam logic [KIND_W-1:0] WK_INPUT   = 4'h0;
	localparam logic [KIND_W-1:0] WK_GAIN    = 4'h1;
	localparam logic [KIND_W-1:0] WK_TRIM    = 4'h2;
	localparam logic [KIND_W-1:0] WK_CONTROL = 4'h3;
	localparam logic [KIND_W-1:0] WK_OFS0    = 4'h4;
	localparam logic [KIND_W-1:0] WK_OFS1    = 4'h5;
	localparam logic [KIND_W-1:0] WK_SELECT  = 4'h6;
	localparam logic [KIND_W-1:0] WK_SEL_ALL = 4'h7;

	// ****************************************************************
	// Control register and reset values
	// ****************************************************************
	localparam int             CTRL_W        = 3;
	localparam int             CTRL_BANK_BIT = 2;
	localparam logic [CTRL_W-1:0] CTRL_DEFAULT = 3'h0;
	localparam logic [GRP_CH-1:0] SEL_DEFAULT  = 8'h00;
	localparam logic [OFS_W-1:0]  OFS_DEFAULT  = 14'h1555;
	localparam logic [WIDTH_16-1:0] IN_DEF16   = 16'h5554;
	localparam logic [WIDTH_14-1:0] IN_DEF14   = 14'h1555;

	typedef enum logic [1:0] {
		DCP_IDLE = 2'b01,
		DCP_CALC = 2'b10
	} dcp_state_e;
endpackage

// *** core/dcp_cal_unit.sv ***
`timescale 1ns/10ps
// Shared gain/offset arithmetic, one result a cycle after start
module dcp_cal_unit #(
	parameter int DATA_W = 16
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              start,
	input  wire logic [DATA_W-1:0] code,
	input  wire logic [DATA_W-1:0] gain,
	input  wire logic [DATA_W-1:0] trim,
	output logic      [DATA_W-1:0] result_q,
	output logic                   done_q
);
	import dcp_pkg::*;

	localparam int SUM_W = DATA_W + 3;
	localparam logic signed [SUM_W-1:0] HALF =
		SUM_W'(1) <<< (DATA_W - 1);
	localparam logic signed [SUM_W-1:0] FULL =
		(SUM_W'(1) <<< DATA_W) - SUM_W'(1);

	logic [2*DATA_W:0]        prod;
	logic signed [SUM_W-1:0]  sum;
	logic [DATA_W-1:0]        result_d;

	always_comb begin
		prod = (2*DATA_W+1)'(code)
			* (2*DATA_W+1)'({1'b0, gain} + 1'b1);
		sum  = $signed({2'b00, prod[2*DATA_W:DATA_W]})
			+ $signed({3'b000, trim}) - HALF;
		// Clamp rather than wrap: a wrapped code is a full-scale jump
		if (sum < 0) begin
			result_d = '0;
		end else if (sum > FULL) begin
			result_d = '1;
		end else begin
			result_d = sum[DATA_W-1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_q <= '0;
			done_q   <= 1'b0;
		end else begin
			if (start) begin
				result_q <= result_d;
			end
			done_q <= start;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_cal_latency;
		start |=> done_q ##1 !done_q || $past(start, 1);
	endproperty
	a_cal_latency: assert property (p_cal_latency)
		else $error("calibration result not one cycle after start");

	property p_cal_floor;
		start && code == '0 && trim == '0 |=> result_q == '0;
	endproperty
	a_cal_floor: assert property (p_cal_floor)
		else $error("negative calibrated sum did not clamp to zero");
endmodule

// *** core/dcp_dac_bank.sv ***
`timescale 1ns/10ps
// Final DAC registers, all channels loaded from their chosen source
module dcp_dac_bank #(
	parameter int               DATA_W = 16,
	parameter logic [DATA_W-1:0] RST   = '0
) (
	input  wire logic                             ref_clk,
	input  wire logic                             rst_n,
	input  wire logic                             load,
	input  wire logic [dcp_pkg::NUM_CH-1:0]       source_sel,
	input  wire logic [dcp_pkg::NUM_CH*DATA_W-1:0] cal_a,
	input  wire logic [dcp_pkg::NUM_CH*DATA_W-1:0] cal_b,
	output logic      [dcp_pkg::NUM_CH*DATA_W-1:0] dac_q
);
	import dcp_pkg::*;

	// Each channel owns its own register; the flat port is only wiring
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		logic [DATA_W-1:0] d;
		logic [DATA_W-1:0] q;
		always_comb begin
			d = q;
			if (load) begin
				d = source_sel[i] ? cal_b[i*DATA_W +: DATA_W]
					: cal_a[i*DATA_W +: DATA_W];
			end
		end
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				q <= RST;
			end else begin
				q <= d;
			end
		end
		assign dac_q[i*DATA_W +: DATA_W] = q;
	end
endmodule

// *** core/dcp_data_path.sv ***
`timescale 1ns/10ps
// How it works
// - Bank select steers input writes to A or B
// - Bank select is global, never per channel
// - Gain and offset trims produce calibrated A/B
// - One shared arithmetic unit, channels served serially
// - Bank A input or trims at select 0 recalc A
// - Bank B input or trims at select 1 recalc B
// - Calibrated registers only written by the arithmetic
// - Per-channel select bits, written one group at a time, choose A or B source
// - Global command sets all select bits
// - Load strobe low updates all DAC registers together
// - Strobe held low updates as data arrives
// - Two offset codes: group 0, groups 1-3
// - Offset codes reset to 5461
// - 16-bit: x*(m+1)/2^16 + c - 2^15
// - 14-bit: x*(m+1)/2^14 + c - 2^13
// - 16-bit input registers reset to 21844
// - 14-bit input registers reset to 5461
// - 16-bit offset code is scaled by four
// - Clear holds outputs at ground, programming continues
// - Busy low while recalculation is in progress
// - Strobe during busy is kept until busy ends
module dcp_data_path #(
	parameter int DATA_W = 16
) (
	input  wire logic                              ref_clk,
	input  wire logic                              rst_n,
	input  wire logic                              wr_valid,
	input  wire logic [dcp_pkg::KIND_W-1:0]        wr_kind,
	input  wire logic [dcp_pkg::CH_W-1:0]          wr_addr,
	input  wire logic [dcp_pkg::MAX_W-1:0]         wr_data,
	input  wire logic                              load_strobe_n,
	input  wire logic                              clear_n,
	output logic      [dcp_pkg::NUM_CH*DATA_W-1:0] dac_code,
	output logic                                   busy_n,
	output logic      [dcp_pkg::NUM_GRP-1:0]       group_signal_ground,
	output logic      [dcp_pkg::OFS_OUT_W-1:0]     offset_code0,
	output logic      [dcp_pkg::OFS_OUT_W-1:0]     offset_code1,
	output logic      [dcp_pkg::CTRL_W-1:0]        control,
	output logic      [dcp_pkg::NUM_CH-1:0]        source_select
);
	import dcp_pkg::*;

	// ****************************************************************
	// Width-dependent reset values
	// ****************************************************************
	localparam logic [DATA_W-1:0] IN_DEF = (DATA_W == WIDTH_16) ?
		DATA_W'(IN_DEF16) : DATA_W'(IN_DEF14);
	localparam logic [DATA_W-1:0] GAIN_DEF = '1;
	localparam logic [DATA_W-1:0] TRIM_DEF = DATA_W'(1) << (DATA_W - 1);
	// Offset outputs start scaled, so they agree with the code from reset
	localparam logic [OFS_OUT_W-1:0] OC_DEF = (DATA_W == WIDTH_16) ?
		OFS_OUT_W'(OFS_DEFAULT) << OFS_SHIFT16 : OFS_OUT_W'(OFS_DEFAULT);

	function automatic logic [PICK_W-1:0] dcp_first(
		input logic [2*NUM_CH-1:0] v
	);
		logic [PICK_W-1:0] idx;
		idx = '0;
		for (int k = 2*NUM_CH - 1; k >= 0; k--) begin
			if (v[k]) begin
				idx = PICK_W'(k);
			end
		end
		return idx;
	endfunction

	function automatic logic [OFS_OUT_W-1:0] dcp_scale(
		input logic [OFS_W-1:0] ofs
	);
		logic [OFS_OUT_W-1:0] s;
		s = OFS_OUT_W'(ofs);
		if (DATA_W == WIDTH_16) begin
			s = OFS_OUT_W'(ofs) << OFS_SHIFT16;
		end
		return s;
	endfunction

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic [DATA_W-1:0]  in_a_q [NUM_CH];
	logic [DATA_W-1:0]  in_b_q [NUM_CH];
	logic [DATA_W-1:0]  gain_q [NUM_CH];
	logic [DATA_W-1:0]  trim_q [NUM_CH];
	logic [DATA_W-1:0]  cal_a_q [NUM_CH];
	logic [DATA_W-1:0]  cal_b_q [NUM_CH];
	logic [DATA_W-1:0]  in_a_d [NUM_CH];
	logic [DATA_W-1:0]  in_b_d [NUM_CH];
	logic [DATA_W-1:0]  gain_d [NUM_CH];
	logic [DATA_W-1:0]  trim_d [NUM_CH];
	logic [DATA_W-1:0]  cal_a_d [NUM_CH];
	logic [DATA_W-1:0]  cal_b_d [NUM_CH];
	logic [NUM_CH-1:0]  pend_a_q, pend_a_d, pend_b_q, pend_b_d;
	logic [NUM_CH-1:0]  sel_q, sel_d;
	logic [CTRL_W-1:0]  ctrl_q, ctrl_d;
	logic [OFS_W-1:0]   ofs0_q, ofs0_d, ofs1_q, ofs1_d;
	dcp_state_e         state_q, state_d;
	logic [PICK_W-1:0]  pick_q, pick_d;
	logic               load_pend_q, load_pend_d;
	logic               strobe_q, apply_q, apply_d;
	logic               busy_n_q, busy_n_d;
	logic [NUM_GRP-1:0] gnd_q, gnd_d;
	logic [OFS_OUT_W-1:0] oc0_q, oc1_q;
	logic               bank_b, busy, strobe_fall, cal_start, cal_done;
	logic [DATA_W-1:0]  cal_code, cal_gain, cal_trim, cal_result;
	logic [CH_W-1:0]    pick_ch;
	logic [NUM_CH*DATA_W-1:0] cal_a_flat, cal_b_flat;

	assign bank_b      = ctrl_q[CTRL_BANK_BIT];
	assign busy        = (|pend_a_q) | (|pend_b_q) | (state_q == DCP_CALC);
	assign strobe_fall = strobe_q & ~load_strobe_n;
	assign pick_ch     = pick_q[CH_W-1:0];

	// ****************************************************************
	// Host writes and recalculation requests
	// ****************************************************************
	always_comb begin
		in_a_d = in_a_q;
		in_b_d = in_b_q;
		gain_d = gain_q;
		trim_d = trim_q;
		sel_d  = sel_q;
		ctrl_d = ctrl_q;
		ofs0_d = ofs0_q;
		ofs1_d = ofs1_q;
		pend_a_d = pend_a_q;
		pend_b_d = pend_b_q;
		// Clear first so that a write in the launch cycle re-arms it
		if (cal_start) begin
			if (pick_q[CH_W]) begin
				pend_b_d[pick_ch] = 1'b0;
			end else begin
				pend_a_d[pick_ch] = 1'b0;
			end
		end
		if (wr_valid) begin
			unique case (wr_kind)
				WK_INPUT: begin
					if (bank_b) begin
						in_b_d[wr_addr]   = wr_data[DATA_W-1:0];
						pend_b_d[wr_addr] = 1'b1;
					end else begin
						in_a_d[wr_addr]   = wr_data[DATA_W-1:0];
						pend_a_d[wr_addr] = 1'b1;
					end
				end
				WK_GAIN, WK_TRIM: begin
					if (wr_kind == WK_GAIN) begin
						gain_d[wr_addr] = wr_data[DATA_W-1:0];
					end else begin
						trim_d[wr_addr] = wr_data[DATA_W-1:0];
					end
					if (bank_b) begin
						pend_b_d[wr_addr] = 1'b1;
					end else begin
						pend_a_d[wr_addr] = 1'b1;
					end
				end
				WK_CONTROL: ctrl_d = wr_data[CTRL_W-1:0];
				WK_OFS0:    ofs0_d = wr_data[OFS_W-1:0];
				WK_OFS1:    ofs1_d = wr_data[OFS_W-1:0];
				WK_SELECT: begin
					sel_d[wr_addr[GRP_W-1:0]*GRP_CH +: GRP_CH] =
						wr_data[GRP_CH-1:0];
				end
				WK_SEL_ALL: sel_d = {NUM_CH{wr_data[0]}};
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Shared calibration sequencer
	// ****************************************************************
	always_comb begin
		state_d   = state_q;
		pick_d    = pick_q;
		cal_start = 1'b0;
		cal_a_d   = cal_a_q;
		cal_b_d   = cal_b_q;
		unique case (state_q)
			DCP_IDLE: begin
				if (|{pend_b_q, pend_a_q}) begin
					pick_d  = dcp_first({pend_b_q, pend_a_q});
					state_d = DCP_CALC;
				end
			end
			DCP_CALC: begin
				if (cal_done) begin
					// Only the arithmetic writes these
					if (pick_q[CH_W]) begin
						cal_b_d[pick_ch] = cal_result;
					end else begin
						cal_a_d[pick_ch] = cal_result;
					end
					state_d = DCP_IDLE;
				end
			end
		endcase
		// Launch is the cycle after the pick so the operands are stable
		cal_start = (state_q == DCP_CALC) & ~cal_done & ~apply_q
			& (pick_q[CH_W] ? pend_b_q[pick_ch] : pend_a_q[pick_ch]);
	end

	assign cal_code = pick_q[CH_W] ? in_b_q[pick_ch] : in_a_q[pick_ch];
	assign cal_gain = gain_q[pick_ch];
	assign cal_trim = trim_q[pick_ch];

	dcp_cal_unit #(
		.DATA_W (DATA_W)
	) u_cal (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.start    (cal_start),
		.code     (cal_code),
		.gain     (cal_gain),
		.trim     (cal_trim),
		.result_q (cal_result),
		.done_q   (cal_done)
	);

	// ****************************************************************
	// Load, busy and clear
	// ****************************************************************
	always_comb begin
		// A held-low strobe acts as a standing request
		load_pend_d = (load_pend_q & ~apply_q) | strobe_fall
			| ~load_strobe_n;
		apply_d  = load_pend_d & ~busy & ~apply_q;
		busy_n_d = ~((|pend_a_d) | (|pend_b_d)
			| (state_d == DCP_CALC));
		gnd_d    = {NUM_GRP{~clear_n}};
	end

	for (genvar i = 0; i < NUM_CH; i++) begin : g_flat
		assign cal_a_flat[i*DATA_W +: DATA_W] = cal_a_q[i];
		assign cal_b_flat[i*DATA_W +: DATA_W] = cal_b_q[i];
	end

	// Registers keep loading under clear; the ground flags mute outputs
	dcp_dac_bank #(
		.DATA_W (DATA_W),
		.RST    (IN_DEF)
	) u_dac (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.load       (apply_q),
		.source_sel (sel_q),
		.cal_a      (cal_a_flat),
		.cal_b      (cal_b_flat),
		.dac_q      (dac_code)
	);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				in_a_q[i]  <= IN_DEF;
				in_b_q[i]  <= IN_DEF;
				gain_q[i]  <= GAIN_DEF;
				trim_q[i]  <= TRIM_DEF;
				cal_a_q[i] <= IN_DEF;
				cal_b_q[i] <= IN_DEF;
			end
			pend_a_q    <= '0;
			pend_b_q    <= '0;
			sel_q       <= {NUM_GRP{SEL_DEFAULT}};
			ctrl_q      <= CTRL_DEFAULT;
			ofs0_q      <= OFS_DEFAULT;
			ofs1_q      <= OFS_DEFAULT;
			state_q     <= DCP_IDLE;
			pick_q      <= '0;
			load_pend_q <= 1'b0;
			strobe_q    <= 1'b1;
			apply_q     <= 1'b0;
			busy_n_q    <= 1'b1;
			gnd_q       <= '0;
			oc0_q       <= OC_DEF;
			oc1_q       <= OC_DEF;
		end else begin
			in_a_q      <= in_a_d;
			in_b_q      <= in_b_d;
			gain_q      <= gain_d;
			trim_q      <= trim_d;
			cal_a_q     <= cal_a_d;
			cal_b_q     <= cal_b_d;
			pend_a_q    <= pend_a_d;
			pend_b_q    <= pend_b_d;
			sel_q       <= sel_d;
			ctrl_q      <= ctrl_d;
			ofs0_q      <= ofs0_d;
			ofs1_q      <= ofs1_d;
			state_q     <= state_d;
			pick_q      <= pick_d;
			load_pend_q <= load_pend_d;
			strobe_q    <= load_strobe_n;
			apply_q     <= apply_d;
			busy_n_q    <= busy_n_d;
			gnd_q       <= gnd_d;
			oc0_q       <= dcp_scale(ofs0_q);
			oc1_q       <= dcp_scale(ofs1_q);
		end
	end

	assign busy_n              = busy_n_q;
	assign group_signal_ground = gnd_q;
	assign offset_code0        = oc0_q;
	assign offset_code1        = oc1_q;
	assign control             = ctrl_q;
	assign source_select       = sel_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_input_write;
		wr_valid && wr_kind == WK_INPUT;
	endsequence

	property p_bank_a;
		s_input_write and !bank_b |=>
			in_a_q[$past(wr_addr)] == $past(wr_data[DATA_W-1:0])
			&& pend_a_q[$past(wr_addr)];
	endproperty
	a_bank_a: assert property (p_bank_a)
		else $error("input write with select 0 missed bank A");

	property p_bank_b;
		s_input_write and bank_b |=>
			in_b_q[$past(wr_addr)] == $past(wr_data[DATA_W-1:0])
			&& pend_b_q[$past(wr_addr)];
	endproperty
	a_bank_b: assert property (p_bank_b)
		else $error("input write with select 1 missed bank B");

	property p_trim_recalc;
		wr_valid && (wr_kind == WK_GAIN || wr_kind == WK_TRIM) |=>
			($past(bank_b) ? pend_b_q[$past(wr_addr)]
				: pend_a_q[$past(wr_addr)]);
	endproperty
	a_trim_recalc: assert property (p_trim_recalc)
		else $error("trim write did not request recalculation");

	property p_busy;
		(|pend_a_q) || (|pend_b_q) |-> !busy_n_q;
	endproperty
	a_busy: assert property (p_busy)
		else $error("busy not shown while recalculation pending");

	property p_no_load_busy;
		apply_q |-> $past(!busy);
	endproperty
	a_no_load_busy: assert property (p_no_load_busy)
		else $error("DAC load taken while busy");

	sequence s_strobe_busy;
		strobe_fall && busy;
	endsequence

	property p_strobe_kept;
		s_strobe_busy |=> load_pend_q;
	endproperty
	a_strobe_kept: assert property (p_strobe_kept)
		else $error("strobe during busy was lost");

	property p_load_soon;
		load_pend_q && !busy && !apply_q |=> apply_q;
	endproperty
	a_load_soon: assert property (p_load_soon)
		else $error("pending load not applied once idle");

	property p_sel_all;
		wr_valid && wr_kind == WK_SEL_ALL |=>
			sel_q == {NUM_CH{$past(wr_data[0])}};
	endproperty
	a_sel_all: assert property (p_sel_all)
		else $error("global select command not applied");

	property p_clear;
		!clear_n |=> group_signal_ground == '1;
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear did not ground outputs");

	property p_ofs_scale;
		##1 offset_code0 == dcp_scale($past(ofs0_q));
	endproperty
	a_ofs_scale: assert property (p_ofs_scale)
		else $error("offset code scaling wrong");
endmodule

// *** verification/dcp_host_model.sv ***
`timescale 1ns/10ps
// ************************
// Host side of the block
// ************************
module dcp_host_model (
	input  wire logic                  ref_clk,
	output logic                       wr_valid,
	output logic [dcp_pkg::KIND_W-1:0] wr_kind,
	output logic [dcp_pkg::CH_W-1:0]   wr_addr,
	output logic [dcp_pkg::MAX_W-1:0]  wr_data,
	output logic                       load_strobe_n,
	output logic                       clear_n
);
	import dcp_pkg::*;
	localparam logic [MAX_W-1:0] OFS_MAX = 16'h2000;

	initial begin
		wr_valid      = 1'b0;
		// Idle lines carry noise; only wr_valid qualifies them
		wr_kind       = KIND_W'($urandom);
		wr_addr       = CH_W'($urandom);
		wr_data       = MAX_W'($urandom);
		load_strobe_n = 1'b1;
		clear_n       = 1'b1;
	end

	// Address and data are inverted after each write so stale values never look held
	task automatic write(input logic [KIND_W-1:0] kind,
		input logic [CH_W-1:0] addr, input logic [MAX_W-1:0] data);
		logic [MAX_W-1:0] d;
		d = data;
		if ((kind == WK_OFS0 || kind == WK_OFS1) && d > OFS_MAX) begin
			d = OFS_MAX;
		end
		@(posedge ref_clk);
		wr_valid <= 1'b1;
		wr_kind  <= kind;
		wr_addr  <= addr;
		wr_data  <= d;
		@(posedge ref_clk);
		wr_valid <= 1'b0;
		wr_addr  <= ~addr;
		wr_data  <= ~d;
	endtask

	task automatic set_load(input logic v);
		@(posedge ref_clk);
		load_strobe_n <= v;
	endtask

	task automatic set_clear(input logic v);
		@(posedge ref_clk);
		clear_n <= v;
	endtask
endmodule

// *** verification/dcp_data_path_tb_top.sv ***
`timescale 1ns/10ps
module dcp_data_path_tb_top;
	import dcp_pkg::*;
	localparam int W  = WIDTH_16;
	localparam int CW = NUM_CH * W;

	// ************************
	// Signals and model state
	// ************************
	logic                ref_clk;
	logic                rst_n;
	logic                wr_valid;
	logic [KIND_W-1:0]   wr_kind;
	logic [CH_W-1:0]     wr_addr;
	logic [MAX_W-1:0]    wr_data;
	logic                load_strobe_n;
	logic                clear_n;
	logic [CW-1:0]       dac_code;
	logic                busy_n;
	logic [NUM_GRP-1:0]  group_signal_ground;
	logic [OFS_OUT_W-1:0] offset_code0;
	logic [OFS_OUT_W-1:0] offset_code1;
	logic [CTRL_W-1:0]   control;
	logic [NUM_CH-1:0]   source_select;
	logic [W-1:0]        in_a [NUM_CH];
	logic [W-1:0]        in_b [NUM_CH];
	logic [W-1:0]        gain [NUM_CH];
	logic [W-1:0]        trim [NUM_CH];
	logic [W-1:0]        cal_a [NUM_CH];
	logic [W-1:0]        cal_b [NUM_CH];
	logic [NUM_CH-1:0]   sel;
	logic                bank;
	logic [CW-1:0]       old;
	logic [MAX_W-1:0]    o0;
	logic [MAX_W-1:0]    o1;
	int                  n_fail;
	int                  cmp_count;
	int                  n;

	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	dcp_host_model i_host (
		.ref_clk      (ref_clk),
		.wr_valid     (wr_valid),
		.wr_kind      (wr_kind),
		.wr_addr      (wr_addr),
		.wr_data      (wr_data),
		.load_strobe_n(load_strobe_n),
		.clear_n      (clear_n)
	);

	dcp_data_path #(.DATA_W(W)) i_dut (
		.ref_clk            (ref_clk),
		.rst_n              (rst_n),
		.wr_valid           (wr_valid),
		.wr_kind            (wr_kind),
		.wr_addr            (wr_addr),
		.wr_data            (wr_data),
		.load_strobe_n      (load_strobe_n),
		.clear_n            (clear_n),
		.dac_code           (dac_code),
		.busy_n             (busy_n),
		.group_signal_ground(group_signal_ground),
		.offset_code0       (offset_code0),
		.offset_code1       (offset_code1),
		.control            (control),
		.source_select      (source_select)
	);

	// ************************
	// Helpers
	// ************************
	task automatic check(input logic [CW-1:0] seen, input logic [CW-1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Saturating gain and offset arithmetic
	function automatic logic [W-1:0] cal(input logic [W-1:0] x, g, t);
		longint v;
		v = ((longint'(x) * (longint'(g) + 1)) >> W) + longint'(t);
		v = v - (longint'(1) << (W - 1));
		if (v < 0) begin
			v = 0;
		end
		if (v > (longint'(1) << W) - 1) begin
			v = (longint'(1) << W) - 1;
		end
		return v[W-1:0];
	endfunction

	function automatic logic [CW-1:0] exp_dac();
		logic [CW-1:0] v;
		for (int i = 0; i < NUM_CH; i++) begin
			v[i*W +: W] = sel[i] ? cal_b[i] : cal_a[i];
		end
		return v;
	endfunction

	task automatic wr(input logic [KIND_W-1:0] k, input int a,
		input logic [MAX_W-1:0] d);
		case (k)
			WK_INPUT: if (bank) in_b[a] = d; else in_a[a] = d;
			WK_GAIN: gain[a] = d;
			WK_TRIM: trim[a] = d;
			WK_CONTROL: bank = d[CTRL_BANK_BIT];
			WK_SELECT: sel[a[1:0]*8 +: 8] = d[7:0];
			WK_SEL_ALL: sel = {NUM_CH{d[0]}};
			default: ;
		endcase
		if (k == WK_INPUT || k == WK_GAIN || k == WK_TRIM) begin
			if (bank) cal_b[a] = cal(in_b[a], gain[a], trim[a]);
			else cal_a[a] = cal(in_a[a], gain[a], trim[a]);
		end
		i_host.write(k, a[CH_W-1:0], d);
	endtask

	task automatic wait_idle;
		int c;
		c = 0;
		@(posedge ref_clk);
		while (busy_n !== 1'b1 && c < 1000) begin
			@(posedge ref_clk);
			c++;
		end
		if (c >= 1000) begin
			check(busy_n, 1'b1);
		end
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	task automatic load_check;
		i_host.set_load(1'b0);
		i_host.set_load(1'b1);
		wait_idle();
		check(dac_code, exp_dac());
		check(source_select, sel);
	endtask

	initial begin
		#200000;
		n_fail++;
		finish_test();
	end

	// ************************
	// Tests
	// ************************
	initial begin
		void'($urandom(83));
		rst_n     = 1'b0;
		n_fail    = 0;
		cmp_count = 0;
		sel       = SEL_DEFAULT;
		bank      = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			in_a[i]  = IN_DEF16;
			in_b[i]  = IN_DEF16;
			gain[i]  = 16'hffff;
			trim[i]  = 16'h8000;
			cal_a[i] = IN_DEF16;
			cal_b[i] = IN_DEF16;
		end
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		check(dac_code, exp_dac());
		check(busy_n, 1'b1);
		check(control, CTRL_DEFAULT);
		check(offset_code0, {OFS_DEFAULT, 2'b00});
		check(offset_code1, {OFS_DEFAULT, 2'b00});
		wr(WK_INPUT, 1, 16'h4000);
		@(posedge ref_clk);
		#1;
		check(busy_n, 1'b0);
		for (int i = 0; i < 6; i++) begin
			n = $urandom_range(NUM_CH - 1);
			// Codes away from the rails and trims near default keep the result in range
			wr(WK_INPUT, n, $urandom_range(16'hf000, 16'h1000));
			wr(WK_GAIN, n, $urandom_range(16'hffff, 16'hc000));
			wr(WK_TRIM, n, $urandom_range(16'h8400, 16'h7c00));
		end
		load_check();
		wr(WK_CONTROL, 0, 16'h0004);
		#1;
		check(control, 3'h4);
		wr(WK_INPUT, 2, 16'h2345);
		wr(WK_GAIN, 1, 16'h9000);
		load_check();
		for (int g = 0; g < NUM_GRP; g++) begin
			wr(WK_SELECT, g, $urandom_range(16'h00ff));
		end
		load_check();
		wr(WK_SEL_ALL, 0, 16'h0001);
		load_check();
		wr(WK_SEL_ALL, 0, 16'h0000);
		wr(WK_CONTROL, 0, 16'h0000);
		wr(WK_TRIM, 1, 16'h8100);
		wr(WK_INPUT, 3, 16'h0000);
		wr(WK_TRIM, 3, 16'h0000);
		wr(WK_INPUT, 4, 16'hffff);
		wr(WK_TRIM, 4, 16'hffff);
		wr(4'hf, 5, 16'h1234);
		load_check();
		old = exp_dac();
		for (int i = 8; i < 16; i++) begin
			wr(WK_INPUT, i, $urandom_range(16'hf000, 16'h1000));
		end
		i_host.set_load(1'b0);
		i_host.set_load(1'b1);
		#1;
		n = 0;
		while (busy_n === 1'b0 && n < 1000) begin
			check(dac_code, old);
			@(posedge ref_clk);
			#1;
			n++;
		end
		check(n >= 4, 1'b1);
		repeat (3) @(posedge ref_clk);
		#1;
		check(dac_code, exp_dac());
		i_host.set_load(1'b0);
		wr(WK_INPUT, 20, $urandom_range(16'hf000, 16'h1000));
		wait_idle();
		check(dac_code, exp_dac());
		i_host.set_load(1'b1);
		i_host.set_clear(1'b0);
		@(posedge ref_clk);
		#1;
		check(group_signal_ground, 4'hf);
		wr(WK_INPUT, 21, 16'h3333);
		load_check();
		i_host.set_clear(1'b1);
		@(posedge ref_clk);
		#1;
		check(group_signal_ground, 4'h0);
		o0 = $urandom_range(16'h2000);
		o1 = $urandom_range(16'h2000);
		wr(WK_OFS0, 0, o0);
		wr(WK_OFS1, 0, o1);
		repeat (3) @(posedge ref_clk);
		#1;
		check(offset_code0, o0 << OFS_SHIFT16);
		check(offset_code1, o1 << OFS_SHIFT16);
		finish_test();
	end
endmodule
